//--- rtl/tioctl_pkg.sv
// shared constants and types for the trigger and sampling control block
package tioctl_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam int unsigned PULSE_MIN_NS = 8000;
  localparam int unsigned PULSE_CYC    =
    (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DC_START_MAX_US = 80;
  localparam int unsigned DC_START_CYC    = DC_START_MAX_US * CLK_MHZ;
  localparam int unsigned ARM_MAX_US      = 70;
  localparam int unsigned ARM_CYC         = ARM_MAX_US * CLK_MHZ;
  localparam int unsigned CH_LAG_MAX_US   = 700;
  localparam int unsigned CH_LAG_CYC      = CH_LAG_MAX_US * CLK_MHZ;

  localparam int CNT_W  = 8;
  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC);

  // rates are carried in millihertz
  localparam int RATE_W = 20;
  localparam logic [RATE_W-1:0] RATE_MIN_MHZ    = 20'h003e8 / 20'h003e8;
  localparam logic [RATE_W-1:0] RATE_HIRES_MAX  = 20'h061a8;
  localparam logic [RATE_W-1:0] RATE_FAST2_MAX  = 20'h7a120;
  localparam logic [RATE_W-1:0] RATE_FAST1_MAX  = 20'hf4240;
  localparam logic [RATE_W-1:0] RATE_FORCED     = 20'h061a8;
  localparam logic [RATE_W-1:0] RATE_RESET      = 20'h061a8;

  // phase accumulator wraps once per second of millihertz
  localparam int ACC_W = 36;
  localparam logic [ACC_W-1:0] ACC_WRAP = 36'h4_a817_c800;

  localparam int MEAS_W = 32;
  localparam int INTG_W = 40;
  localparam int NCH    = 2;

  typedef enum logic [2:0] {
    completion_pulse_mode      = 3'h0,
    periodic_pulse_mode        = 3'h1,
    threshold_level_mode       = 3'h2,
    accumulated_threshold_mode = 3'h3,
    trigger_output_disabled    = 3'h4
  } tioctl_tmode_t;

  typedef enum logic [2:0] {
    steady_level_continuous  = 3'h0,
    steady_level_single_shot = 3'h1,
    energy_continuous        = 3'h2,
    one_shot_energy_capture  = 3'h3,
    swing_continuous         = 3'h4,
    one_shot_swing_capture   = 3'h5
  } tioctl_amode_t;

  typedef enum logic [2:0] {
    CH_IDLE  = 3'b001,
    CH_RUN   = 3'b010,
    CH_ARMED = 3'b100
  } tioctl_ch_st_t;
endpackage

//--- rtl/tioctl_rate_if.sv
// rate generator request and tick bundle
`timescale 1ns/1ps
interface tioctl_rate_if;
  import tioctl_pkg::*;
  logic [RATE_W-1:0] rate;
  logic              run;
  logic              restart;
  logic              tick;
  modport gen  (input rate, input run, input restart, output tick);
  modport user (output rate, output run, output restart, input tick);
endinterface

//--- rtl/tioctl_rate_tick.sv
// fractional rate tick generator, one pulse per period of rate
`timescale 1ns/1ps
module tioctl_rate_tick
(
  input  wire logic   clk_in,
  input  wire logic   sys_rst_in,
  tioctl_rate_if.gen  r
);
  import tioctl_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             tick;
  } tioctl_rt_st_t;

  tioctl_rt_st_t st_q;
  tioctl_rt_st_t st_d;
  logic [ACC_W-1:0] sum;

  always_comb
  begin
    st_d      = st_q;
    sum       = st_q.acc + ACC_W'(r.rate);
    st_d.tick = 1'b0;
    if (r.restart || !r.run)
    begin
      // restart puts the first tick one full period later
      st_d.acc = '0;
    end
    else if (sum >= ACC_WRAP)
    begin
      st_d.acc  = sum - ACC_WRAP;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.acc = sum;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign r.tick = st_q.tick;
endmodule

//--- rtl/tioctl_stretch.sv
// retriggerable pulse stretcher holding its output for a fixed count
`timescale 1ns/1ps
module tioctl_stretch
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic start_in,
  output logic      busy_out
);
  import tioctl_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
  } tioctl_sx_st_t;

  tioctl_sx_st_t st_q;
  tioctl_sx_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (start_in)
      st_d.cnt = PULSE_CNT;
    else if (st_q.cnt != '0)
      st_d.cnt = st_q.cnt - CNT_W'(1);
    st_d.busy = (st_d.cnt != '0);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign busy_out = st_q.busy;
endmodule

//--- rtl/tioctl_top.sv
// trigger output, trigger input, converter and responsivity control
`timescale 1ns/1ps
// How it works
// - output mode: completion, periodic, level, integral, off
// - completion pulse per finished reading, 8 us
// - periodic pulses 0.001 to 1000 Hz
// - level mode: active above threshold, level
// - integral mode: active while sum below limit
// - common start keeps channel triggers aligned
// - separate starts time from own run start
// - programmable output polarity and idle level
// - external trigger enable and edge select
// - external edge acts like run/stop on both
// - pulse and swing modes: trigger only arms
// - single steady conversion starts within 80 us
// - single capture armed within 70 us
// - precision picks converter in steady modes only
// - high resolution limits rate to 25 Hz
// - fast converter capped by installed module count
// - precision change forces illegal rate to 25 Hz
// - attenuator selects combined responsivity and indicator
// - user calibration substitutes user responsivity
module tioctl_top
(
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire tioctl_pkg::tioctl_tmode_t  trig_mode_in,
  input  wire logic                       trig_active_high_in,
  input  wire logic [tioctl_pkg::RATE_W-1:0] trig_freq_in,
  input  wire logic [tioctl_pkg::MEAS_W-1:0] level_thresh_in,
  input  wire logic [tioctl_pkg::INTG_W-1:0] intg_thresh_in,
  input  wire logic                       intg_clear_in,
  input  wire logic [1:0]                 reading_done_in,
  input  wire logic [tioctl_pkg::MEAS_W-1:0] meas_value_in,
  input  wire logic                       power_valid_in,
  input  wire logic [tioctl_pkg::MEAS_W-1:0] power_sample_in,
  input  wire logic                       ext_trig_pin_in,
  input  wire logic                       ext_trig_enable_in,
  input  wire logic                       external_edge_select_in,
  input  wire logic [1:0]                 run_key_in,
  input  wire logic [1:0]                 capture_done_in,
  input  wire tioctl_pkg::tioctl_amode_t  acq_mode_in,
  input  wire logic                       converter_precision_select_in,
  input  wire logic                       two_modules_in,
  input  wire logic                       sample_rate_wr_in,
  input  wire logic [tioctl_pkg::RATE_W-1:0] sample_rate_setting_in,
  input  wire logic                       attenuator_present_in,
  input  wire logic                       attenuator_select_in,
  input  wire logic                       user_responsivity_enable_in,
  input  wire logic [31:0]                user_responsivity_value_in,
  input  wire logic [31:0]                resp_bare_in,
  input  wire logic [31:0]                resp_atten_in,
  output logic                            trig_out,
  output logic [1:0]                      conv_start_out,
  output logic [1:0]                      gate_out,
  output logic [1:0]                      armed_out,
  output logic                            hires_adc_out,
  output logic [tioctl_pkg::RATE_W-1:0]   sample_rate_out,
  output logic [31:0]                     resp_out,
  output logic [31:0]                     module_responsivity_view_out,
  output logic                            atten_ind_out,
  output logic                            user_cal_ind_out
);
  import tioctl_pkg::*;

  typedef struct packed {
    tioctl_ch_st_t [NCH-1:0] ch;
    logic [NCH-1:0]    conv;
    logic [NCH-1:0]    restart;
    logic [NCH-1:0]    arm;
    logic [2:0]        sync;
    logic              prec;
    logic              hires;
    logic [RATE_W-1:0] rate;
    logic              lvl;
    logic [INTG_W-1:0] sum;
    logic              trig;
    logic [31:0]       resp;
    logic [31:0]       mresp;
    logic              atten_ind;
    logic              user_ind;
  } tioctl_top_st_t;

  tioctl_top_st_t st_q;
  tioctl_top_st_t st_d;

  tioctl_rate_if ch_if [NCH] ();
  tioctl_rate_if fq_if ();

  logic [NCH-1:0]    ch_tick;
  logic              pulse_start;
  logic              stretch_busy;
  logic              ext_edge;
  logic              single;
  logic              steady;
  logic              active;
  logic              ev;
  logic [RATE_W-1:0] rate_max;
  logic [INTG_W:0]   sum_ext;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      // both channels share one restart cycle on a common start
      assign ch_if[gi].rate    = st_q.rate;
      assign ch_if[gi].restart = st_q.restart[gi];
      assign ch_if[gi].run     = (st_q.ch[gi] == CH_RUN);
      assign ch_tick[gi]       = ch_if[gi].tick;
      tioctl_rate_tick u_ch_tick
      (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .r          (ch_if[gi])
      );
    end
  endgenerate

  assign fq_if.rate    = trig_freq_in;
  assign fq_if.run     = (trig_mode_in == periodic_pulse_mode);
  assign fq_if.restart = 1'b0;

  tioctl_rate_tick u_fq_tick
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .r          (fq_if)
  );

  // retrigger inside a pulse extends it rather than merging edges
  tioctl_stretch u_stretch
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (pulse_start),
    .busy_out   (stretch_busy)
  );

  always_comb
  begin
    pulse_start = 1'b0;
    case (trig_mode_in)
      completion_pulse_mode: pulse_start = |reading_done_in;
      periodic_pulse_mode:   pulse_start = fq_if.tick;
      default:               pulse_start = 1'b0;
    endcase
  end

  always_comb
  begin
    st_d    = st_q;
    ev      = 1'b0;
    active  = 1'b0;
    sum_ext = '0;
    single  = (acq_mode_in == steady_level_single_shot) ||
              (acq_mode_in == one_shot_energy_capture) ||
              (acq_mode_in == one_shot_swing_capture);
    steady  = (acq_mode_in == steady_level_continuous) ||
              (acq_mode_in == steady_level_single_shot);

    // the second and third stages feed the edge detector
    st_d.sync = {st_q.sync[1:0], ext_trig_pin_in};
    ext_edge  = ext_trig_enable_in && (external_edge_select_in ?
                (st_q.sync[1] && !st_q.sync[2]) :
                (!st_q.sync[1] && st_q.sync[2]));

    st_d.conv    = '0;
    st_d.restart = '0;
    for (int i = 0; i < NCH; i++)
    begin
      ev = ext_edge || run_key_in[i];
      case (st_q.ch[i])
        CH_IDLE:
        begin
          if (ev && single && steady)
            st_d.conv[i] = 1'b1;
          else if (ev && single)
            st_d.ch[i] = CH_ARMED;
          else if (ev)
          begin
            st_d.ch[i]      = CH_RUN;
            st_d.restart[i] = 1'b1;
            st_d.conv[i]    = steady;
          end
        end
        CH_RUN:
        begin
          if (ev)
            st_d.ch[i] = CH_IDLE;
          else if (steady && ch_tick[i])
            st_d.conv[i] = 1'b1;
        end
        CH_ARMED:
        begin
          if (capture_done_in[i])
            st_d.ch[i] = CH_IDLE;
        end
        default: st_d.ch[i] = CH_IDLE;
      endcase
      // capture modes are enabled, never forced at the edge
      st_d.arm[i] = (st_d.ch[i] == CH_ARMED) ||
                    ((st_d.ch[i] == CH_RUN) && !steady);
    end

    rate_max = converter_precision_select_in ? RATE_HIRES_MAX :
               (two_modules_in ? RATE_FAST2_MAX : RATE_FAST1_MAX);
    st_d.prec  = converter_precision_select_in;
    st_d.hires = converter_precision_select_in && steady;
    if (sample_rate_wr_in)
    begin
      if (sample_rate_setting_in < RATE_MIN_MHZ)
        st_d.rate = RATE_MIN_MHZ;
      else if (sample_rate_setting_in > rate_max)
        st_d.rate = rate_max;
      else
        st_d.rate = sample_rate_setting_in;
    end
    else if (st_q.rate > rate_max)
      st_d.rate = (st_q.prec != converter_precision_select_in) ?
                  RATE_FORCED : rate_max;

    // equal readings leave the level where it was
    if (|reading_done_in)
    begin
      if (meas_value_in > level_thresh_in)
        st_d.lvl = 1'b1;
      else if (meas_value_in < level_thresh_in)
        st_d.lvl = 1'b0;
    end

    // saturating sum so a long run cannot wrap back below the limit
    if (intg_clear_in || trig_mode_in != accumulated_threshold_mode)
      st_d.sum = '0;
    else if (power_valid_in)
    begin
      sum_ext  = {1'b0, st_q.sum} + (INTG_W + 1)'(power_sample_in);
      st_d.sum = sum_ext[INTG_W] ? '1 : sum_ext[INTG_W-1:0];
    end

    case (trig_mode_in)
      completion_pulse_mode:      active = stretch_busy;
      periodic_pulse_mode:        active = stretch_busy;
      threshold_level_mode:       active = st_q.lvl;
      accumulated_threshold_mode: active = st_q.sum < intg_thresh_in;
      default:                    active = 1'b0;
    endcase
    st_d.trig = active ~^ trig_active_high_in;

    st_d.mresp     = (attenuator_select_in && attenuator_present_in) ?
                     resp_atten_in : resp_bare_in;
    st_d.resp      = user_responsivity_enable_in ?
                     user_responsivity_value_in : st_d.mresp;
    st_d.atten_ind = attenuator_select_in && attenuator_present_in &&
                     !user_responsivity_enable_in;
    st_d.user_ind  = user_responsivity_enable_in;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_q      <= '0;
      st_q.ch[0] <= CH_IDLE;
      st_q.ch[1] <= CH_IDLE;
      st_q.rate <= RATE_RESET;
      st_q.trig <= 1'b1;
      st_q.prec <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign trig_out                     = st_q.trig;
  assign conv_start_out               = st_q.conv;
  assign armed_out                    = st_q.arm;
  assign hires_adc_out                = st_q.hires;
  assign sample_rate_out              = st_q.rate;
  assign resp_out                     = st_q.resp;
  assign module_responsivity_view_out = st_q.mresp;
  assign atten_ind_out                = st_q.atten_ind;
  assign user_cal_ind_out             = st_q.user_ind;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      gate_out[i] = (st_q.ch[i] == CH_RUN);
  end
endmodule

//--- test/tioctl_bench.sv
// self-checking bench for the trigger and sampling control block
`timescale 1ns/1ps
module tioctl_bench;
  import tioctl_pkg::*;
  logic              clk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  tioctl_tmode_t     trig_mode_in = completion_pulse_mode;
  tioctl_amode_t     acq_mode_in = steady_level_continuous;
  logic              trig_active_high_in = 1'b0;
  logic [RATE_W-1:0] trig_freq_in = 20'hf4240;
  logic [MEAS_W-1:0] level_thresh_in = 32'h64;
  logic [INTG_W-1:0] intg_thresh_in = 40'h64;
  logic              intg_clear_in = 1'b0;
  logic [1:0]        reading_done_in = 2'h0;
  logic [MEAS_W-1:0] meas_value_in = 32'h0;
  logic              power_valid_in = 1'b0;
  logic [MEAS_W-1:0] power_sample_in = 32'h3c;
  logic              ext_trig_pin_in;
  logic              ext_trig_enable_in = 1'b0;
  logic              external_edge_select_in = 1'b1;
  logic [1:0]        run_key_in = 2'h0;
  logic [1:0]        capture_done_in = 2'h0;
  logic              converter_precision_select_in = 1'b1;
  logic              two_modules_in = 1'b1;
  logic              sample_rate_wr_in = 1'b0;
  logic [RATE_W-1:0] sample_rate_setting_in = 20'h0;
  logic              attenuator_present_in = 1'b0;
  logic              attenuator_select_in = 1'b0;
  logic              user_responsivity_enable_in = 1'b0;
  logic [31:0]       user_responsivity_value_in = 32'h33;
  logic [31:0]       resp_bare_in = 32'h11;
  logic [31:0]       resp_atten_in = 32'h22;
  logic              trig_out, hires_adc_out, atten_ind_out;
  logic              user_cal_ind_out, ext_go = 1'b0;
  logic [1:0]        conv_start_out, gate_out, armed_out;
  logic [RATE_W-1:0] sample_rate_out;
  logic [31:0]       resp_out, module_responsivity_view_out;
  int                fail_count = 0, checks = 0, cycles = 0;

  tioctl_top u_dut (.clk_in, .sys_rst_in, .trig_mode_in, .trig_active_high_in,
    .trig_freq_in, .level_thresh_in, .intg_thresh_in, .intg_clear_in,
    .reading_done_in, .meas_value_in, .power_valid_in, .power_sample_in,
    .ext_trig_pin_in, .ext_trig_enable_in, .external_edge_select_in,
    .run_key_in, .capture_done_in, .acq_mode_in,
    .converter_precision_select_in, .two_modules_in, .sample_rate_wr_in,
    .sample_rate_setting_in, .attenuator_present_in, .attenuator_select_in,
    .user_responsivity_enable_in, .user_responsivity_value_in,
    .resp_bare_in, .resp_atten_in, .trig_out, .conv_start_out, .gate_out,
    .armed_out, .hires_adc_out, .sample_rate_out, .resp_out,
    .module_responsivity_view_out, .atten_ind_out, .user_cal_ind_out);
  tioctl_ext_inst u_ext (.clk_in, .go_in(ext_go),
    .ext_trig_pin_out(ext_trig_pin_in));

  always #25 clk_in = ~clk_in;

  task automatic print_verdict();
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic smp(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic rd(input logic [31:0] v);
    @(posedge clk_in);
    meas_value_in <= v;
    reading_done_in <= 2'h2;
    @(posedge clk_in);
    reading_done_in <= 2'h0;
  endtask

  task automatic t_cmplt(input logic pol);
    int n;
    @(posedge clk_in);
    trig_mode_in <= completion_pulse_mode;
    trig_active_high_in <= pol;
    smp(3);
    chk(trig_out, !pol);
    rd(32'h0);
    n = 0;
    while (trig_out !== pol && n < 4)
    begin
      @(negedge clk_in);
      n++;
    end
    n = 0;
    while (trig_out === pol && n < 400)
    begin
      @(negedge clk_in);
      n++;
    end
    chk(40'(n), 40'(PULSE_CYC));
  endtask

  task automatic t_periodic();
    int n;
    logic was;
    n = 0;
    was = 1'b0;
    @(posedge clk_in);
    trig_mode_in <= periodic_pulse_mode;
    repeat (50000)
    begin
      @(negedge clk_in);
      if (trig_out === 1'b0 && !was)
        n++;
      was = (trig_out === 1'b0);
    end
    chk(40'(n), 40'h2);
  endtask

  task automatic key(input tioctl_amode_t m, input logic [1:0] v,
                     input logic [5:0] exp);
    @(posedge clk_in);
    acq_mode_in <= m;
    @(posedge clk_in);
    run_key_in <= v;
    @(posedge clk_in);
    run_key_in <= 2'h0;
    // conv_start stands for one cycle only, so look in that cycle
    @(negedge clk_in);
    chk({gate_out, armed_out, conv_start_out}, exp);
  endtask

  task automatic t_ext(input tioctl_amode_t m, input logic en,
                       input logic sel, input logic [3:0] exp);
    logic [1:0] cs, ar;
    cs = 2'h0;
    ar = 2'h0;
    @(posedge clk_in);
    acq_mode_in <= m;
    ext_trig_enable_in <= en;
    external_edge_select_in <= sel;
    // an armed channel ignores events, so free both channels first
    capture_done_in <= 2'h3;
    @(posedge clk_in);
    capture_done_in <= 2'h0;
    @(posedge clk_in);
    ext_go <= 1'b1;
    @(posedge clk_in);
    ext_go <= 1'b0;
    // first nonzero value shows both channels move together
    repeat (40)
    begin
      @(negedge clk_in);
      if (cs == 2'h0)
        cs = conv_start_out;
      if (ar == 2'h0)
        ar = armed_out;
    end
    chk({cs, ar}, exp);
  endtask

  task automatic wr(input logic [19:0] v, input logic [19:0] exp);
    @(posedge clk_in);
    sample_rate_setting_in <= v;
    sample_rate_wr_in <= 1'b1;
    @(posedge clk_in);
    sample_rate_wr_in <= 1'b0;
    smp(1);
    chk(sample_rate_out, exp);
  endtask

  task automatic t_resp(input logic [2:0] pse, input logic [33:0] exp);
    @(posedge clk_in);
    {attenuator_present_in, attenuator_select_in,
     user_responsivity_enable_in} <= pse;
    smp(2);
    chk({resp_out, atten_ind_out, user_cal_ind_out}, exp);
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    smp(2);
    chk({sample_rate_out, trig_out}, {20'h061a8, 1'b1});
    t_cmplt(1'b1);
    t_cmplt(1'b0);
    t_periodic();
    @(posedge clk_in);
    trig_mode_in <= threshold_level_mode;
    rd(32'hc8);
    smp(3);
    chk(trig_out, 1'b0);
    rd(32'h32);
    smp(3);
    chk(trig_out, 1'b1);
    @(posedge clk_in);
    trig_mode_in <= accumulated_threshold_mode;
    repeat (2)
    begin
      smp(3);
      chk(trig_out, 1'b0);
      @(posedge clk_in);
      power_valid_in <= 1'b1;
      @(posedge clk_in);
      power_valid_in <= 1'b0;
    end
    smp(3);
    chk(trig_out, 1'b1);
    @(posedge clk_in);
    trig_mode_in <= trigger_output_disabled;
    rd(32'hc8);
    smp(4);
    chk(trig_out, 1'b1);
    key(steady_level_continuous, 2'h1, 6'h11);
    key(steady_level_continuous, 2'h2, 6'h32);
    key(steady_level_continuous, 2'h3, 6'h00);
    key(steady_level_single_shot, 2'h1, 6'h01);
    key(one_shot_swing_capture, 2'h2, 6'h08);
    t_ext(steady_level_single_shot, 1'b1, 1'b1, 4'hc);
    t_ext(steady_level_single_shot, 1'b1, 1'b0, 4'hc);
    t_ext(steady_level_single_shot, 1'b0, 1'b1, 4'h0);
    t_ext(one_shot_energy_capture, 1'b1, 1'b1, 4'h3);
    @(posedge clk_in);
    capture_done_in <= 2'h3;
    @(posedge clk_in);
    capture_done_in <= 2'h0;
    smp(1);
    chk(armed_out, 2'h0);
    @(posedge clk_in);
    acq_mode_in <= steady_level_continuous;
    smp(2);
    chk(hires_adc_out, 1'b1);
    wr(20'h07530, 20'h061a8);
    wr(20'h00000, 20'h00001);
    @(posedge clk_in);
    converter_precision_select_in <= 1'b0;
    wr(20'hf4240, 20'h7a120);
    chk(hires_adc_out, 1'b0);
    @(posedge clk_in);
    two_modules_in <= 1'b0;
    wr(20'hf4240, 20'hf4240);
    @(posedge clk_in);
    converter_precision_select_in <= 1'b1;
    acq_mode_in <= energy_continuous;
    smp(2);
    chk({hires_adc_out, sample_rate_out}, {1'b0, 20'h061a8});
    t_resp(3'h2, {32'h11, 2'h0});
    t_resp(3'h6, {32'h22, 2'h2});
    t_resp(3'h7, {32'h33, 2'h1});
    chk(module_responsivity_view_out, 32'h22);
    print_verdict();
  end
endmodule

//--- test/tioctl_ext_inst.sv
// far-side instrument driving the external trigger pin
`timescale 1ns/1ps
module tioctl_ext_inst
(
  input  wire logic clk_in,
  input  wire logic go_in,
  output logic      ext_trig_pin_out
);
  logic [3:0] cnt_q = 4'h0;
  initial ext_trig_pin_out = 1'b0;
  // driven ttl line, so idle low is a real level
  always @(posedge clk_in)
  begin
    if (go_in)
      cnt_q <= 4'h6;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    ext_trig_pin_out <= go_in || cnt_q > 4'h1;
  end
endmodule

//--- test/tioctl_sva.sv
// port assertions for the trigger and sampling control block
`timescale 1ns/1ps
module tioctl_sva
(
  input wire logic                          clk_in,
  input wire logic                          sys_rst_in,
  input wire tioctl_pkg::tioctl_tmode_t     trig_mode_in,
  input wire logic                          trig_active_high_in,
  input wire logic [1:0]                    reading_done_in,
  input wire logic [tioctl_pkg::MEAS_W-1:0] meas_value_in,
  input wire logic [tioctl_pkg::MEAS_W-1:0] level_thresh_in,
  input wire logic [1:0]                    run_key_in,
  input wire tioctl_pkg::tioctl_amode_t     acq_mode_in,
  input wire logic                          converter_precision_select_in,
  input wire logic                          user_responsivity_enable_in,
  input wire logic [31:0]                   user_responsivity_value_in,
  input wire logic                          trig_out,
  input wire logic [1:0]                    conv_start_out,
  input wire logic [1:0]                    gate_out,
  input wire logic [1:0]                    armed_out,
  input wire logic [tioctl_pkg::RATE_W-1:0] sample_rate_out,
  input wire logic [31:0]                   resp_out,
  input wire logic                          user_cal_ind_out
);
  import tioctl_pkg::*;
  logic       act;
  logic       hit;
  logic [7:0] act_cnt_q;
  assign act = (trig_out == trig_active_high_in);
  assign hit = (meas_value_in > level_thresh_in);
  // run length of the active level, read back when it drops
  always_ff @(posedge clk_in or posedge sys_rst_in)
    if (sys_rst_in)
      act_cnt_q <= 8'h00;
    else
      act_cnt_q <= act ? act_cnt_q + 8'h01 : 8'h00;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_cmplt_pulse: assert property (
    trig_mode_in == completion_pulse_mode && |reading_done_in
    && $stable(trig_active_high_in) |-> ##[2:3] act)
    else $error("completion pulse missing");
  a_pulse_width: assert property (
    trig_mode_in inside {completion_pulse_mode, periodic_pulse_mode}
    && !act && $past(act) && $stable(trig_active_high_in)
    && $past(trig_active_high_in, 2) == trig_active_high_in
    |-> act_cnt_q >= PULSE_CNT)
    else $error("trigger pulse too short");
  a_level_track: assert property (
    trig_mode_in == threshold_level_mode && |reading_done_in
    && meas_value_in != level_thresh_in
    |-> ##2 act == $past(hit, 2))
    else $error("level output wrong");
  a_off_idle: assert property (
    (trig_mode_in == trigger_output_disabled
    && $stable(trig_active_high_in)) [*3] |-> !act)
    else $error("disabled output not idle");
  a_steady_run: assert property (
    acq_mode_in == steady_level_continuous && $stable(acq_mode_in)
    && run_key_in[0] && !gate_out[0]
    |=> gate_out[0] && conv_start_out[0])
    else $error("run key did not open gate");
  a_single_conv: assert property (
    acq_mode_in == steady_level_single_shot && $stable(acq_mode_in)
    && run_key_in[0] |=> conv_start_out[0] && !gate_out[0])
    else $error("single conversion not started");
  a_swing_arm: assert property (
    acq_mode_in == one_shot_swing_capture && $stable(acq_mode_in)
    && run_key_in[1] && !armed_out[1]
    |=> armed_out[1] && !conv_start_out[1])
    else $error("single capture not armed");
  a_hires_cap: assert property (
    converter_precision_select_in [*2]
    |-> sample_rate_out <= RATE_HIRES_MAX)
    else $error("rate above high resolution limit");
  a_user_resp: assert property (
    user_responsivity_enable_in |=> user_cal_ind_out
    && resp_out == $past(user_responsivity_value_in))
    else $error("user responsivity not applied");
endmodule
bind tioctl_top tioctl_sva u_sva (.clk_in, .sys_rst_in, .trig_mode_in,
  .trig_active_high_in, .reading_done_in, .meas_value_in,
  .level_thresh_in, .run_key_in, .acq_mode_in,
  .converter_precision_select_in, .user_responsivity_enable_in,
  .user_responsivity_value_in, .trig_out, .conv_start_out, .gate_out,
  .armed_out, .sample_rate_out, .resp_out, .user_cal_ind_out);
